// ==== verilog/cam_regs.svh ====
/*
 Register offsets, field positions, reset values and sizes for the counter array
 mode control block. Assumes an 8-bit special-function-register bus with 8-bit
 addresses.
*/
`ifndef CAM_REGS_SVH
`define CAM_REGS_SVH

`define CAM_MODE5_ADDR      8'hce
`define CAM_MODE0_ADDR      8'hda
`define CAM_MODE1_ADDR      8'hdb
`define CAM_MODE2_ADDR      8'hdc
`define CAM_MODE3_ADDR      8'hdd
`define CAM_MODE4_ADDR      8'hde
`define CAM_CNT_LO_ADDR     8'hf9
`define CAM_CNT_HI_ADDR     8'hfa
`define CAM_CMP_LO0_ADDR    8'hfb
`define CAM_CMP_LO1_ADDR    8'he9
`define CAM_CMP_LO2_ADDR    8'heb
`define CAM_CMP_LO3_ADDR    8'hed
`define CAM_CMP_LO4_ADDR    8'hfd
`define CAM_CMP_LO5_ADDR    8'hd2
`define CAM_CMP_HI0_ADDR    8'hfc
`define CAM_CMP_HI1_ADDR    8'hea
`define CAM_CMP_HI2_ADDR    8'hec
`define CAM_CMP_HI3_ADDR    8'hee
`define CAM_CMP_HI4_ADDR    8'hfe
`define CAM_CMP_HI5_ADDR    8'hd3

`define CAM_BIT_WIDE        7
`define CAM_BIT_CMP_EN      6
`define CAM_BIT_RISE        5
`define CAM_BIT_FALL        4
`define CAM_BIT_MATCH       3
`define CAM_BIT_TOGGLE      2
`define CAM_BIT_PWM         1
`define CAM_BIT_IRQ         0

`define CAM_MODE_RESET      8'h00
`define CAM_CNT_RESET       16'h0000
`define CAM_NUM_MOD         6
`define CAM_WDT_MOD         5

`endif

// ==== verilog/cam_pkg.sv ====
/*
 Types shared by the counter array mode control block.
 Assumes cam_regs.svh is compiled alongside.
*/
package cam_pkg;

	typedef struct packed {
		logic       wide_mode_select;
		logic       compare_enable;
		logic       rise_capture_enable;
		logic       fall_capture_enable;
		logic       match_flag_enable;
		logic       toggle_enable;
		logic       pulse_mod_enable;
		logic       flag_irq_enable;
	} cam_mode_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cam_bus_t;

	typedef struct packed {
		cam_mode_t  mode;
		logic [15:0] cmp;
		logic [15:0] rld;
		logic       pin;
		logic       flag;
		logic       in_d;
	} cam_chan_t;

endpackage

// ==== verilog/cam_channel.sv ====
/*
 One capture/compare channel: edge capture, match, toggle, PWM and frequency
 output. Assumes a synchronised capture input and a free counter on ref_clk.
*/
`include "cam_regs.svh"

module cam_channel (
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	input  wire logic [15:0]         count,
	input  wire logic [1:0]          cyc_len,
	input  wire cam_pkg::cam_mode_t  mode,
	input  wire logic [15:0]         cmp,
	input  wire logic                cap_in,
	output logic                     cap_evt,
	output logic                     match_evt,
	output logic                     pin
);

	typedef struct packed {
		logic in_d;
		logic pin;
	} cam_ch_state_t;

	cam_ch_state_t st_r;
	cam_ch_state_t st_nxt;
	logic [15:0]   mask;
	logic        rise;
	logic        fall;
	logic        eq;

	//////////////////////////////////////////////////////////////////////////
	// Event detection
	always_comb begin
		mask = 16'h00ff >> 0;
		case (cyc_len)
			2'h0: mask = 16'h00ff;
			2'h1: mask = 16'h01ff;
			2'h2: mask = 16'h03ff;
			default: mask = 16'h07ff;
		endcase
		if (mode.wide_mode_select) begin
			mask = 16'hffff;
		end
	end

	assign rise      = cap_in & ~st_r.in_d;
	assign fall      = ~cap_in & st_r.in_d;
	assign eq        = mode.compare_enable && ((count & mask) == (cmp & mask));
	assign cap_evt   = (mode.rise_capture_enable & rise) | (mode.fall_capture_enable & fall);
	assign match_evt = eq;

	//////////////////////////////////////////////////////////////////////////
	// Output pin
	always_comb begin
		st_nxt      = st_r;
		st_nxt.in_d = cap_in;
		if (mode.toggle_enable && mode.pulse_mod_enable) begin
			if (eq) begin
				st_nxt.pin = ~st_r.pin;
			end
		end else if (mode.pulse_mod_enable) begin
			st_nxt.pin = mode.compare_enable && ((count & mask) >= (cmp & mask));
		end else if (mode.toggle_enable && eq) begin
			st_nxt.pin = ~st_r.pin;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin = st_r.pin;

	property p_toggle;
		@(posedge ref_clk) disable iff (sys_rst)
		(mode.toggle_enable && !mode.pulse_mod_enable && eq) |=> (st_r.pin != $past(st_r.pin));
	endproperty
	a_toggle: assert property (p_toggle) else $error("Pin did not toggle on match");

	property p_freq;
		@(posedge ref_clk) disable iff (sys_rst)
		(mode.toggle_enable && mode.pulse_mod_enable && !eq) |=> (st_r.pin == $past(st_r.pin));
	endproperty
	a_freq: assert property (p_freq) else $error("Frequency output moved without match");

	property p_pwm;
		@(posedge ref_clk) disable iff (sys_rst)
		(!mode.toggle_enable && mode.pulse_mod_enable && !mode.compare_enable) |=> !st_r.pin;
	endproperty
	a_pwm: assert property (p_pwm) else $error("PWM high with comparator off");

endmodule // cam_channel

// ==== verilog/cam_top.sv ====
/*
 Counter array module mode control: six mode registers, the shared 16-bit
 counter with high-byte snapshot, compare registers and watchdog lock.
 Assumes a single-cycle SFR bus on ref_clk with 8-bit address and data.
*/
// Summary of operation
// - Bit 7 selects 16-bit PWM resolution
// - Bit 6 enables comparator against counter
// - Bit 5 enables rising edge capture
// - Bit 4 enables falling edge capture
// - Bit 3 match sets capture/compare flag
// - Bit 2 toggles pin on match
// - Toggle plus PWM gives frequency output
// - Bit 1 drives PWM on pin
// - Bit 0 gates flag onto interrupt
// - Watchdog locks module 5 mode register writes; compare low/high writes still change its bit 6
// - Watchdog locks counter byte writes
// - High byte reads snapshot latched on low read
// - Counter is 16 bits, low and high bytes
// - Compare low write clears comparator enable
// - Compare high write sets comparator enable
`include "cam_regs.svh"

module cam_top (
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	input  wire cam_pkg::cam_bus_t   sfr,
	output logic [7:0]               sfr_rdata,
	output logic                     sfr_hit,
	input  wire logic                count_run,
	input  wire logic                watchdog_enable,
	input  wire logic [1:0]          cyc_len,
	input  wire logic [5:0]          flag_clr,
	input  wire logic [5:0]          capture_in,
	output logic [5:0]               module_output_pin,
	output logic [5:0]               capcmp_flag,
	output logic                     irq
);

	typedef struct packed {
		cam_pkg::cam_mode_t [5:0] mode;
		logic [5:0][15:0]         cmp;
		logic [15:0]              cnt;
		logic [7:0]               snap;
		logic [5:0]               flag;
		logic [7:0]               rdata;
		logic                     hit;
		logic [5:0]               s1;
		logic [5:0]               s2;
	} cam_state_t;

	cam_state_t st_r;
	cam_state_t st_nxt;

	logic [5:0] cap_evt;
	logic [5:0] match_evt;

	//////////////////////////////////////////////////////////////////////////
	// Address decode helpers
	function automatic logic [2:0] mode_idx(input logic [7:0] a, output logic hit);
		hit = 1'b1;
		case (a)
			`CAM_MODE0_ADDR: mode_idx = 3'h0;
			`CAM_MODE1_ADDR: mode_idx = 3'h1;
			`CAM_MODE2_ADDR: mode_idx = 3'h2;
			`CAM_MODE3_ADDR: mode_idx = 3'h3;
			`CAM_MODE4_ADDR: mode_idx = 3'h4;
			`CAM_MODE5_ADDR: mode_idx = 3'h5;
			default: begin
				mode_idx = 3'h0;
				hit = 1'b0;
			end
		endcase
	endfunction

	function automatic logic [2:0] lo_idx(input logic [7:0] a, output logic hit);
		hit = 1'b1;
		case (a)
			`CAM_CMP_LO0_ADDR: lo_idx = 3'h0;
			`CAM_CMP_LO1_ADDR: lo_idx = 3'h1;
			`CAM_CMP_LO2_ADDR: lo_idx = 3'h2;
			`CAM_CMP_LO3_ADDR: lo_idx = 3'h3;
			`CAM_CMP_LO4_ADDR: lo_idx = 3'h4;
			`CAM_CMP_LO5_ADDR: lo_idx = 3'h5;
			default: begin
				lo_idx = 3'h0;
				hit = 1'b0;
			end
		endcase
	endfunction

	function automatic logic [2:0] hi_idx(input logic [7:0] a, output logic hit);
		hit = 1'b1;
		case (a)
			`CAM_CMP_HI0_ADDR: hi_idx = 3'h0;
			`CAM_CMP_HI1_ADDR: hi_idx = 3'h1;
			`CAM_CMP_HI2_ADDR: hi_idx = 3'h2;
			`CAM_CMP_HI3_ADDR: hi_idx = 3'h3;
			`CAM_CMP_HI4_ADDR: hi_idx = 3'h4;
			`CAM_CMP_HI5_ADDR: hi_idx = 3'h5;
			default: begin
				hi_idx = 3'h0;
				hit = 1'b0;
			end
		endcase
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Channels
	genvar g;
	generate
		for (g = 0; g < `CAM_NUM_MOD; g++) begin : g_ch
			cam_channel u_ch (
				.ref_clk   (ref_clk),
				.sys_rst   (sys_rst),
				.count     (st_r.cnt),
				.cyc_len   (cyc_len),
				.mode      (st_r.mode[g]),
				.cmp       (st_r.cmp[g]),
				.cap_in    (st_r.s2[g]),
				.cap_evt   (cap_evt[g]),
				.match_evt (match_evt[g]),
				.pin       (module_output_pin[g])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic       mh;
		logic       lh;
		logic       hh;
		logic [2:0] mi;
		logic [2:0] li;
		logic [2:0] hi;
		mh = 1'b0;
		lh = 1'b0;
		hh = 1'b0;
		mi = mode_idx(sfr.addr, mh);
		li = lo_idx(sfr.addr, lh);
		hi = hi_idx(sfr.addr, hh);
		st_nxt = st_r;
		st_nxt.s1 = capture_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.hit = 1'b0;
		st_nxt.rdata = 8'h00;

		if (count_run) begin
			st_nxt.cnt = st_r.cnt + 16'h0001;
		end

		// Register writes
		if (sfr.wr) begin
			if (mh && !(mi == 3'(`CAM_WDT_MOD) && watchdog_enable)) begin
				st_nxt.mode[mi] = sfr.wdata;
			end
			if (lh) begin
				st_nxt.cmp[li][7:0] = sfr.wdata;
				st_nxt.mode[li].compare_enable = 1'b0;
			end
			if (hh) begin
				st_nxt.cmp[hi][15:8] = sfr.wdata;
				st_nxt.mode[hi].compare_enable = 1'b1;
			end
			if (!watchdog_enable) begin
				if (sfr.addr == `CAM_CNT_LO_ADDR) begin
					st_nxt.cnt[7:0] = sfr.wdata;
				end
				if (sfr.addr == `CAM_CNT_HI_ADDR) begin
					st_nxt.cnt[15:8] = sfr.wdata;
				end
			end
		end

		// Register reads
		if (sfr.rd) begin
			st_nxt.hit = 1'b1;
			if (mh) begin
				st_nxt.rdata = st_r.mode[mi];
			end else if (lh) begin
				st_nxt.rdata = st_r.cmp[li][7:0];
			end else if (hh) begin
				st_nxt.rdata = st_r.cmp[hi][15:8];
			end else if (sfr.addr == `CAM_CNT_LO_ADDR) begin
				st_nxt.rdata = st_r.cnt[7:0];
				st_nxt.snap = st_r.cnt[15:8];
			end else if (sfr.addr == `CAM_CNT_HI_ADDR) begin
				st_nxt.rdata = st_r.snap;
			end else begin
				st_nxt.hit = 1'b0;
			end
		end

		// Capture and match, set wins over clear
		for (int i = 0; i < `CAM_NUM_MOD; i++) begin
			if (flag_clr[i]) begin
				st_nxt.flag[i] = 1'b0;
			end
			if (cap_evt[i]) begin
				st_nxt.cmp[i] = st_r.cnt;
				st_nxt.flag[i] = 1'b1;
			end
			if (match_evt[i] && st_r.mode[i].match_flag_enable) begin
				st_nxt.flag[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Outputs
	always_comb begin
		irq = 1'b0;
		for (int i = 0; i < `CAM_NUM_MOD; i++) begin
			irq = irq | (st_r.flag[i] & st_r.mode[i].flag_irq_enable);
		end
	end

	assign sfr_rdata   = st_r.rdata;
	assign sfr_hit     = st_r.hit;
	assign capcmp_flag = st_r.flag;

	//////////////////////////////////////////////////////////////////////////
	// Checks
	property p_wide;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_r.mode[5].wide_mode_select && !st_r.mode[5].toggle_enable
			&& st_r.mode[5].pulse_mod_enable && st_r.mode[5].compare_enable
			&& st_r.cnt >= st_r.cmp[5] && !match_evt[5]) |=> module_output_pin[5];
	endproperty
	a_wide: assert property (p_wide) else $error("Wide PWM level wrong");

	property p_cmp_off;
		@(posedge ref_clk) disable iff (sys_rst)
		(!st_r.mode[1].compare_enable && st_r.mode[1].match_flag_enable
			&& !capcmp_flag[1] && !cap_evt[1]) |=> !capcmp_flag[1];
	endproperty
	a_cmp_off: assert property (p_cmp_off) else $error("Match without comparator");

	property p_rise;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_r.mode[3].rise_capture_enable && st_r.s2[3] && !$past(st_r.s2[3])
			&& !flag_clr[3]) |=> (capcmp_flag[3] && st_r.cmp[3] == $past(st_r.cnt));
	endproperty
	a_rise: assert property (p_rise) else $error("Rising capture missed");

	property p_fall;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_r.mode[4].fall_capture_enable && !st_r.s2[4] && $past(st_r.s2[4])
			&& !flag_clr[4]) |=> (capcmp_flag[4] && st_r.cmp[4] == $past(st_r.cnt));
	endproperty
	a_fall: assert property (p_fall) else $error("Falling capture missed");

	property p_match;
		@(posedge ref_clk) disable iff (sys_rst)
		(match_evt[0] && st_r.mode[0].match_flag_enable) |=> capcmp_flag[0];
	endproperty
	a_match: assert property (p_match) else $error("Match did not set flag");

	property p_irq;
		@(posedge ref_clk) disable iff (sys_rst)
		(capcmp_flag[0] && st_r.mode[0].flag_irq_enable) |-> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt not raised");

	property p_wdt_mode;
		@(posedge ref_clk) disable iff (sys_rst)
		(sfr.wr && sfr.addr == `CAM_MODE5_ADDR && watchdog_enable)
			|=> st_r.mode[5] == $past(st_r.mode[5]);
	endproperty
	a_wdt_mode: assert property (p_wdt_mode) else $error("Module 5 written under watchdog");

	property p_wdt_cnt;
		@(posedge ref_clk) disable iff (sys_rst)
		(sfr.wr && sfr.addr == `CAM_CNT_HI_ADDR && watchdog_enable && !count_run)
			|=> st_r.cnt == $past(st_r.cnt);
	endproperty
	a_wdt_cnt: assert property (p_wdt_cnt) else $error("Counter written under watchdog");

	property p_snap;
		@(posedge ref_clk) disable iff (sys_rst)
		(sfr.rd && sfr.addr == `CAM_CNT_LO_ADDR) |=> st_r.snap == $past(st_r.cnt[15:8]);
	endproperty
	a_snap: assert property (p_snap) else $error("Snapshot not latched");

	property p_lo_clr;
		@(posedge ref_clk) disable iff (sys_rst)
		(sfr.wr && sfr.addr == `CAM_CMP_LO0_ADDR) |=> !st_r.mode[0].compare_enable;
	endproperty
	a_lo_clr: assert property (p_lo_clr) else $error("Low write kept enable");

	property p_hi_set;
		@(posedge ref_clk) disable iff (sys_rst)
		(sfr.wr && sfr.addr == `CAM_CMP_HI0_ADDR) |=> st_r.mode[0].compare_enable;
	endproperty
	a_hi_set: assert property (p_hi_set) else $error("High write missed enable");

	property p_snap_rd;
		@(posedge ref_clk) disable iff (sys_rst)
		(sfr.rd && sfr.addr == `CAM_CNT_HI_ADDR) |=> sfr_rdata == $past(st_r.snap);
	endproperty
	a_snap_rd: assert property (p_snap_rd) else $error("High read not from snapshot");

	property p_cnt_inc;
		@(posedge ref_clk) disable iff (sys_rst)
		(count_run && !(sfr.wr && (sfr.addr == `CAM_CNT_LO_ADDR
			|| sfr.addr == `CAM_CNT_HI_ADDR))) |=> st_r.cnt == $past(st_r.cnt) + 16'h0001;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) else $error("Counter did not advance");

	property p_wdt_lo;
		@(posedge ref_clk) disable iff (sys_rst)
		(sfr.wr && sfr.addr == `CAM_CNT_LO_ADDR && watchdog_enable && !count_run)
			|=> st_r.cnt == $past(st_r.cnt);
	endproperty
	a_wdt_lo: assert property (p_wdt_lo) else $error("Counter low written under watchdog");

	property p_rst_zero;
		@(posedge ref_clk) disable iff (sys_rst)
		$fell(sys_rst) |-> (st_r.cnt == 16'h0000 && st_r.mode == 48'h0
			&& st_r.flag == 6'h00);
	endproperty
	a_rst_zero: assert property (p_rst_zero) else $error("State not zero after reset");

	property p_wide_lo;
		@(posedge ref_clk) disable iff (sys_rst)
		(st_r.mode[5].wide_mode_select && !st_r.mode[5].toggle_enable
			&& st_r.mode[5].pulse_mod_enable && st_r.cnt < st_r.cmp[5])
			|=> !module_output_pin[5];
	endproperty
	a_wide_lo: assert property (p_wide_lo) else $error("Wide PWM high below compare");

endmodule // cam_top

// ==== tb/cam_pin_model.sv ====
/*
 Far-side pin model: drives the capture inputs and counts output pin toggles.
 Assumes cam_top pins clocked by ref_clk with an active-high async reset.
*/
module cam_pin_model (
	input  wire logic            ref_clk,
	input  wire logic            sys_rst,
	input  wire logic [5:0]      cap_req,
	input  wire logic [5:0]      module_output_pin,
	output logic      [5:0]      capture_in,
	output logic      [5:0][7:0] toggle_cnt
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [5:0] pin_d;

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			capture_in <= '0;
			pin_d      <= '0;
			toggle_cnt <= '0;
		end else begin
			capture_in <= cap_req;
			pin_d      <= module_output_pin;
			for (int i = 0; i < 6; i++)
				if (module_output_pin[i] != pin_d[i])
					toggle_cnt[i] <= toggle_cnt[i] + 8'h01;
		end
	end
endmodule // cam_pin_model

// ==== tb/cam_top_tb.sv ====
/*
 Self-checking bench for cam_top: register table loop, then reset, snapshot,
 watchdog lock, compare writes, match, capture and PWM cases.
 Assumes cam_pin_model on the pin side.
*/
module cam_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
		logic       hit;
	} cam_row_t;

	logic              ref_clk;
	logic              sys_rst;
	cam_pkg::cam_bus_t sfr;
	logic [7:0]        sfr_rdata;
	logic              sfr_hit;
	logic              count_run;
	logic              watchdog_enable;
	logic [1:0]        cyc_len;
	logic [5:0]        flag_clr;
	logic [5:0]        capture_in;
	logic [5:0]        module_output_pin;
	logic [5:0]        capcmp_flag;
	logic              irq;
	logic [5:0]        cap_req;
	logic [5:0][7:0]   toggle_cnt;
	logic [7:0]        t2;
	logic [7:0]        t5;
	int                fail_count;
	int                samples_checked;

	localparam logic [7:0] cmp_lo_a [6] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hd2};
	localparam logic [7:0] all_a [8] = '{8'hce, 8'hda, 8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hf9, 8'hfa};
	localparam cam_row_t rows [11] = '{
		'{8'hda, 8'h80, 8'h80, 1'b1},
		'{8'hdb, 8'h40, 8'h40, 1'b1},
		'{8'hdc, 8'h20, 8'h20, 1'b1},
		'{8'hdd, 8'h10, 8'h10, 1'b1},
		'{8'hde, 8'h08, 8'h08, 1'b1},
		'{8'hce, 8'h04, 8'h04, 1'b1},
		'{8'hda, 8'h02, 8'h02, 1'b1},
		'{8'hdb, 8'h01, 8'h01, 1'b1},
		'{8'hdc, 8'hff, 8'hff, 1'b1},
		'{8'hf9, 8'ha5, 8'ha5, 1'b1},
		'{8'h80, 8'h5a, 8'h00, 1'b0}
	};

	cam_top u_dut (
		.ref_clk           (ref_clk),
		.sys_rst           (sys_rst),
		.sfr               (sfr),
		.sfr_rdata         (sfr_rdata),
		.sfr_hit           (sfr_hit),
		.count_run         (count_run),
		.watchdog_enable   (watchdog_enable),
		.cyc_len           (cyc_len),
		.flag_clr          (flag_clr),
		.capture_in        (capture_in),
		.module_output_pin (module_output_pin),
		.capcmp_flag       (capcmp_flag),
		.irq               (irq)
	);

	cam_pin_model u_pins (
		.ref_clk           (ref_clk),
		.sys_rst           (sys_rst),
		.cap_req           (cap_req),
		.module_output_pin (module_output_pin),
		.capture_in        (capture_in),
		.toggle_cnt        (toggle_cnt)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		sfr.wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		sfr.rd <= 1'b0;
		#1;
		check(sfr_rdata, e);
	endtask

	task automatic set_cnt(input logic [15:0] v);
		sfr_wr(8'hf9, v[7:0]);
		sfr_wr(8'hfa, v[15:8]);
	endtask

	task automatic set_cmp(input int m, input logic [15:0] v);
		sfr_wr(cmp_lo_a[m], v[7:0]);
		sfr_wr(cmp_lo_a[m] + 8'h01, v[15:8]);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		#20000;
		fail_count++;
		print_verdict();
	end

	initial begin
		sys_rst = 1'b1;
		sfr = '0;
		count_run = 1'b0;
		watchdog_enable = 1'b0;
		cyc_len = 2'b00;
		flag_clr = '0;
		cap_req = '0;
		fail_count = 0;
		samples_checked = 0;
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			sfr_wr(rows[i].addr, rows[i].wdata);
			rd_chk(rows[i].addr, rows[i].exp);
			check({7'h00, sfr_hit}, {7'h00, rows[i].hit});
		end
		$display("test table done");

		@(posedge ref_clk) sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		foreach (all_a[i]) rd_chk(all_a[i], 8'h00);
		check({2'b00, capcmp_flag}, 8'h00);
		$display("test reset done");

		set_cnt(16'h1234);
		rd_chk(8'hf9, 8'h34);
		rd_chk(8'hfa, 8'h12);
		sfr_wr(8'hfa, 8'h56);
		rd_chk(8'hfa, 8'h12);
		rd_chk(8'hf9, 8'h34);
		rd_chk(8'hfa, 8'h56);
		$display("test snapshot done");

		@(posedge ref_clk) watchdog_enable <= 1'b1;
		sfr_wr(8'hce, 8'hff);
		rd_chk(8'hce, 8'h00);
		set_cnt(16'h7777);
		rd_chk(8'hf9, 8'h34);
		rd_chk(8'hfa, 8'h56);
		sfr_wr(8'hda, 8'h11);
		rd_chk(8'hda, 8'h11);
		@(posedge ref_clk) watchdog_enable <= 1'b0;
		sfr_wr(8'hce, 8'h04);
		rd_chk(8'hce, 8'h04);
		$display("test watchdog done");

		sfr_wr(8'hfc, 8'h00);
		rd_chk(8'hda, 8'h51);
		sfr_wr(8'hfb, 8'h10);
		rd_chk(8'hda, 8'h11);
		$display("test compare enable done");

		sfr_wr(8'hda, 8'h49);
		sfr_wr(8'hdb, 8'h48);
		sfr_wr(8'hdc, 8'h44);
		sfr_wr(8'hce, 8'h46);
		foreach (cmp_lo_a[m]) set_cmp(m, 16'h0010);
		set_cnt(16'h0000);
		t2 = toggle_cnt[2];
		t5 = toggle_cnt[5];
		@(posedge ref_clk) count_run <= 1'b1;
		repeat (40) @(posedge ref_clk);
		count_run <= 1'b0;
		repeat (3) @(posedge ref_clk);
		#1;
		check({6'h00, capcmp_flag[1:0]}, 8'h03);
		check({7'h00, irq}, 8'h01);
		check(toggle_cnt[2] - t2, 8'h01);
		check(toggle_cnt[5] - t5, 8'h01);
		@(posedge ref_clk) flag_clr <= 6'h01;
		@(posedge ref_clk) flag_clr <= 6'h00;
		repeat (2) @(posedge ref_clk);
		#1;
		check({6'h00, capcmp_flag[1:0]}, 8'h02);
		check({7'h00, irq}, 8'h00);
		$display("test match done");

		sfr_wr(8'hdd, 8'h20);
		sfr_wr(8'hde, 8'h10);
		set_cnt(16'h1234);
		@(posedge ref_clk) cap_req <= 6'h10;
		repeat (8) @(posedge ref_clk);
		#1;
		check({6'h00, capcmp_flag[4:3]}, 8'h00);
		@(posedge ref_clk) cap_req <= 6'h08;
		for (int k = 0; k < 10 && capcmp_flag[4:3] !== 2'b11; k++) @(posedge ref_clk);
		#1;
		check({6'h00, capcmp_flag[4:3]}, 8'h03);
		rd_chk(8'hed, 8'h34);
		rd_chk(8'hee, 8'h12);
		rd_chk(8'hfd, 8'h34);
		rd_chk(8'hfe, 8'h12);
		$display("test capture done");

		sfr_wr(8'hce, 8'h42);
		set_cmp(5, 16'h0080);
		set_cnt(16'h0090);
		repeat (4) @(posedge ref_clk);
		#1;
		check({7'h00, module_output_pin[5]}, 8'h01);
		set_cnt(16'h0110);
		repeat (4) @(posedge ref_clk);
		#1;
		check({7'h00, module_output_pin[5]}, 8'h00);
		for (int k = 1; k < 4; k++) begin
			@(posedge ref_clk) cyc_len <= 2'(k);
			set_cnt(16'h0010 | (16'h0080 << k));
			repeat (4) @(posedge ref_clk);
			#1;
			check({7'h00, module_output_pin[5]}, 8'h01);
			set_cnt(16'h0010 | (16'h0100 << k));
			repeat (4) @(posedge ref_clk);
			#1;
			check({7'h00, module_output_pin[5]}, 8'h00);
		end
		sfr_wr(8'hce, 8'hc2);
		set_cmp(5, 16'h0100);
		repeat (4) @(posedge ref_clk);
		#1;
		check({7'h00, module_output_pin[5]}, 8'h01);
		set_cnt(16'h00f0);
		repeat (4) @(posedge ref_clk);
		#1;
		check({7'h00, module_output_pin[5]}, 8'h00);
		$display("test pwm done");
		print_verdict();
	end
endmodule // cam_top_tb
